// *** src/mic_regs.vh ***
`ifndef MIC_REGS_VH
`define MIC_REGS_VH

// Register offsets on the plain register port.
`define MIC_OFS_OPTION 8'h81
`define MIC_OFS_CTRL 8'h0b
`define MIC_OFS_CTRL_MIRROR 8'h8b
`define MIC_OFS_PFLAGS 8'h0c
`define MIC_OFS_PENABLES 8'h8c
`define MIC_OFS_ANALOG_SEL 8'h91
`define MIC_OFS_PIN_CHG_SEL 8'h96

// Field positions in interrupt_control.
`define MIC_IC_GLOBAL_EN 7
`define MIC_IC_PERIPH_EN 6
`define MIC_IC_TIMER0_EN 5
`define MIC_IC_EXTIE 4
`define MIC_IC_PCIE 3
`define MIC_IC_TIMER0_FLAG 2
`define MIC_IC_EXTIF 1
`define MIC_IC_PCIF 0

// Field positions in peripheral_flags and peripheral_enables.
`define MIC_PF_EEPROM 7
`define MIC_PF_CONV 6
`define MIC_PF_COMP 3
`define MIC_PF_TMR1 0
`define MIC_PF_MASK 8'hc9

// Edge select position in the option register.
`define MIC_OPT_EDGE 6

// The external pin shares port A bit 2.
`define MIC_EXT_PIN_BIT 2

// Reset values.
`define MIC_RST_CTRL 8'h00
`define MIC_RST_PFLAGS 8'h00
`define MIC_RST_PENABLES 8'h00
`define MIC_RST_OPTION 8'hff
`define MIC_RST_ANALOG_SEL 8'hff
`define MIC_RST_PIN_CHG_SEL 6'h00

// Timing, in instruction cycles, and the vector address.
`define MIC_LATENCY_TCY 3
`define MIC_VECTOR_ADDR 13'h0004

`endif

// *** src/mic_sync.v ***
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a bundle of asynchronous pins.
module mic_sync #(
  parameter WIDTH = 1
) (
  input wire clock_i,
  input wire srst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // The first stage is read only by the second stage.
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule // mic_sync

`default_nettype wire

// *** src/mic_interrupt_controller.v ***
// Overview of operation
// - Seven sources: external pin, timer0, port change, comparator, converter, timer1, EEPROM.
// - Global enable at control bit 7 gates every interrupt; reset clears it.
// - Return from service sets the global enable again.
// - Taking an interrupt clears global enable, pushes return address, loads 0004h.
// - Latency is three instruction cycles, plus synchroniser slip for pin events.
// - Flags set on their event regardless of any enable.
// - Clearing global enable drops an imminent vector; the flags stay pending.
// - External pin is edge triggered; option bit 6 selects rising or falling.
// - Valid external edge sets control bit 1; enable sits at bit 4.
// - Enabled event wakes sleep regardless of global enable, which decides branching.
// - Timer0 rollover sets control bit 2; its enable is bit 5.
// - Port change sets control bit 0, enable bit 3, per-pin select register.
// - Change coinciding with a port read still sets the flag.
// - Conversion done sets peripheral flag bit 6; enable at bit 6.
// - Peripheral flags at bits 7, 6, 3, 0; other sources leave them alone.
// - Only the return program counter is saved on entry.
// - Analog pins read zero and deliver no digital edges.
// - External flag may set any time; recognition samples once per Q1.
// - Wake with global enable set runs the prefetched instruction, then vectors.
`timescale 1ns/100ps
`default_nettype none
`include "mic_regs.vh"

module mic_interrupt_controller #(
  parameter LATENCY_TCY = `MIC_LATENCY_TCY,
  parameter PC_WIDTH = 13
) (
  input wire clock_i,
  input wire srst_i,
  // Register port.
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output wire [7:0] reg_rdata_o,
  // Core sequencer.
  input wire q1_i,
  input wire core_sleep_i,
  input wire return_from_service_i,
  input wire [PC_WIDTH-1:0] return_pc_i,
  input wire port_read_i,
  output wire irq_request_o,
  output wire wake_o,
  output wire vector_load_o,
  output wire [PC_WIDTH-1:0] vector_addr_o,
  output wire stack_push_o,
  output wire [PC_WIDTH-1:0] stack_data_o,
  output wire [5:0] port_a_value_o,
  // Event sources.
  input wire [5:0] port_a_pins_i,
  input wire timer_zero_ovf_i,
  input wire comparator_change_i,
  input wire conv_done_i,
  input wire timer1_rollover_i,
  input wire eeprom_done_i
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;
  localparam [3:0] LAT_LAST = LATENCY_TCY[3:0] - 4'h1;

  reg [7:0] interrupt_control_r;
  reg [7:0] interrupt_control_nxt;
  reg [7:0] peripheral_flags_r;
  reg [7:0] peripheral_flags_nxt;
  reg [7:0] peripheral_enables_r;
  reg [7:0] option_r;
  reg [7:0] analog_select_r;
  reg [5:0] pin_change_select_r;
  reg [7:0] rdata_r;
  reg [5:0] port_last_r;
  reg [5:0] port_value_r;
  reg ext_prev_r;
  reg state_r;
  reg state_nxt;
  reg [3:0] lat_cnt_r;
  reg [3:0] lat_cnt_nxt;
  reg fire_nxt;
  reg irq_request_r;
  reg wake_r;
  reg vector_load_r;
  reg stack_push_r;
  reg [PC_WIDTH-1:0] stack_data_r;
  reg [PC_WIDTH-1:0] vector_addr_r;

  wire [5:0] pins_sync;
  wire [5:0] pins_digital;
  wire ext_level;
  wire ext_edge;
  wire port_change;
  wire core_pending;
  wire periph_pending;
  wire any_pending;
  wire request_now;
  wire wr_ctrl;
  wire wr_pflags;

  // Port A pins are asynchronous, so they pass two flops before use.
  mic_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .async_i(port_a_pins_i),
    .sync_o(pins_sync)
  );

  // Analog pins are forced to zero, which also kills their edges.
  assign pins_digital = pins_sync & ~analog_select_r[5:0];

  // External pin edge; polarity chosen by the option bit.
  assign ext_level = pins_digital[`MIC_EXT_PIN_BIT];
  assign ext_edge = option_r[`MIC_OPT_EDGE] ? (ext_level & ~ext_prev_r) : (~ext_level & ext_prev_r);

  // A selected pin that differs from the value at the last port read.
  assign port_change = |((pins_digital ^ port_last_r) & pin_change_select_r);

  // Core flags gated by their enables, peripheral flags by the group enable.
  assign core_pending = |(interrupt_control_r[5:3] & interrupt_control_r[2:0]);
  assign periph_pending = interrupt_control_r[`MIC_IC_PERIPH_EN] & (|(peripheral_flags_r & peripheral_enables_r));
  assign any_pending = core_pending | periph_pending;
  assign request_now = interrupt_control_r[`MIC_IC_GLOBAL_EN] & any_pending;

  assign wr_ctrl = reg_we_i & ((reg_addr_i == `MIC_OFS_CTRL) | (reg_addr_i == `MIC_OFS_CTRL_MIRROR));
  assign wr_pflags = reg_we_i & (reg_addr_i == `MIC_OFS_PFLAGS);

  // Latency sequencer: recognition at a Q1, vector after the set number of cycles.
  // Counting whole instruction cycles keeps the latency the same for any instruction length.
  always @*
  begin
    state_nxt = state_r;
    lat_cnt_nxt = lat_cnt_r;
    fire_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (q1_i && request_now)
        begin
          state_nxt = ST_WAIT;
          lat_cnt_nxt = 4'h0;
        end
      end
      ST_WAIT:
      begin
        if (!interrupt_control_r[`MIC_IC_GLOBAL_EN] || !any_pending)
        begin
          // Flags are left alone so the source is taken once enabled again.
          state_nxt = ST_IDLE;
        end
        else if (q1_i)
        begin
          if (lat_cnt_r == LAT_LAST)
          begin
            fire_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
          else
          begin
            lat_cnt_nxt = lat_cnt_r + 4'h1;
          end
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Control register: writes first, then hardware updates, so a flag set wins over a written clear, and entry's global enable clear wins over any set.
  always @*
  begin
    interrupt_control_nxt = interrupt_control_r;
    if (wr_ctrl)
    begin
      interrupt_control_nxt = reg_wdata_i;
    end
    if (return_from_service_i)
    begin
      interrupt_control_nxt[`MIC_IC_GLOBAL_EN] = 1'b1;
    end
    if (fire_nxt)
    begin
      interrupt_control_nxt[`MIC_IC_GLOBAL_EN] = 1'b0;
    end
    if (timer_zero_ovf_i)
    begin
      interrupt_control_nxt[`MIC_IC_TIMER0_FLAG] = 1'b1;
    end
    if (ext_edge)
    begin
      interrupt_control_nxt[`MIC_IC_EXTIF] = 1'b1;
    end
    if (port_change)
    begin
      interrupt_control_nxt[`MIC_IC_PCIF] = 1'b1;
    end
  end

  // Peripheral flags: unimplemented bits stay zero; each source touches only its own bit.
  always @*
  begin
    peripheral_flags_nxt = peripheral_flags_r;
    if (wr_pflags)
    begin
      peripheral_flags_nxt = reg_wdata_i & `MIC_PF_MASK;
    end
    if (eeprom_done_i)
    begin
      peripheral_flags_nxt[`MIC_PF_EEPROM] = 1'b1;
    end
    if (conv_done_i)
    begin
      peripheral_flags_nxt[`MIC_PF_CONV] = 1'b1;
    end
    if (comparator_change_i)
    begin
      peripheral_flags_nxt[`MIC_PF_COMP] = 1'b1;
    end
    if (timer1_rollover_i)
    begin
      peripheral_flags_nxt[`MIC_PF_TMR1] = 1'b1;
    end
  end

  // Register storage and the configuration that steers the pin logic.
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      interrupt_control_r <= `MIC_RST_CTRL;
      peripheral_flags_r <= `MIC_RST_PFLAGS;
      peripheral_enables_r <= `MIC_RST_PENABLES;
      option_r <= `MIC_RST_OPTION;
      analog_select_r <= `MIC_RST_ANALOG_SEL;
      pin_change_select_r <= `MIC_RST_PIN_CHG_SEL;
    end
    else
    begin
      interrupt_control_r <= interrupt_control_nxt;
      peripheral_flags_r <= peripheral_flags_nxt;
      if (reg_we_i && (reg_addr_i == `MIC_OFS_PENABLES))
      begin
        peripheral_enables_r <= reg_wdata_i & `MIC_PF_MASK;
      end
      if (reg_we_i && (reg_addr_i == `MIC_OFS_OPTION))
      begin
        option_r <= reg_wdata_i;
      end
      if (reg_we_i && (reg_addr_i == `MIC_OFS_ANALOG_SEL))
      begin
        analog_select_r <= reg_wdata_i;
      end
      if (reg_we_i && (reg_addr_i == `MIC_OFS_PIN_CHG_SEL))
      begin
        pin_change_select_r <= reg_wdata_i[5:0];
      end
    end
  end

  // Read data stands for exactly the cycle after the read strobe.
  // Unmapped addresses read as zero.
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rdata_r <= 8'h00;
    end
    else if (reg_re_i)
    begin
      case (reg_addr_i)
        `MIC_OFS_CTRL: rdata_r <= interrupt_control_r;
        `MIC_OFS_CTRL_MIRROR: rdata_r <= interrupt_control_r;
        `MIC_OFS_PFLAGS: rdata_r <= peripheral_flags_r;
        `MIC_OFS_PENABLES: rdata_r <= peripheral_enables_r;
        `MIC_OFS_OPTION: rdata_r <= option_r;
        `MIC_OFS_ANALOG_SEL: rdata_r <= analog_select_r;
        `MIC_OFS_PIN_CHG_SEL: rdata_r <= {2'b00, pin_change_select_r};
        default: rdata_r <= 8'h00;
      endcase
    end
    else
    begin
      rdata_r <= 8'h00;
    end
  end

  // Port history: the reference for change detection is the value seen at the last read.
  // A change landing in the read cycle is absorbed into the new reference but still sets the flag.
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      port_last_r <= 6'h00;
      port_value_r <= 6'h00;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      port_value_r <= pins_digital;
      ext_prev_r <= ext_level;
      if (port_read_i)
      begin
        port_last_r <= pins_digital;
      end
    end
  end

  // Sequencer state and the core-facing outputs.
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      state_r <= ST_IDLE;
      lat_cnt_r <= 4'h0;
      irq_request_r <= 1'b0;
      wake_r <= 1'b0;
      vector_load_r <= 1'b0;
      stack_push_r <= 1'b0;
      stack_data_r <= {PC_WIDTH{1'b0}};
      vector_addr_r <= {PC_WIDTH{1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      lat_cnt_r <= lat_cnt_nxt;
      irq_request_r <= request_now;
      // Wake ignores the global enable; the sequencer decides whether to branch.
      wake_r <= core_sleep_i & any_pending;
      vector_load_r <= fire_nxt;
      stack_push_r <= fire_nxt;
      if (fire_nxt)
      begin
        // Only the return address is pushed; working state is software's job.
        stack_data_r <= return_pc_i;
        vector_addr_r <= `MIC_VECTOR_ADDR;
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign irq_request_o = irq_request_r;
  assign wake_o = wake_r;
  assign vector_load_o = vector_load_r;
  assign vector_addr_o = vector_addr_r;
  assign stack_push_o = stack_push_r;
  assign stack_data_o = stack_data_r;
  assign port_a_value_o = port_value_r;

endmodule // mic_interrupt_controller

`default_nettype wire

// *** tb/mic_ic_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// Checker for the vector, wake and read-data outputs of the controller.
module mic_ic_props #(
  parameter PC_WIDTH = 13
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic q1_i,
  input wire logic core_sleep_i,
  input wire logic [PC_WIDTH-1:0] return_pc_i,
  input wire logic irq_request_o,
  input wire logic wake_o,
  input wire logic vector_load_o,
  input wire logic [PC_WIDTH-1:0] vector_addr_o,
  input wire logic stack_push_o,
  input wire logic [PC_WIDTH-1:0] stack_data_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Entry pushes, loads the fixed vector and drops the request.
  property p_push;
    vector_load_o |-> stack_push_o;
  endproperty
  a_push: assert property (p_push) else $error("vector without push");
  property p_vaddr;
    vector_load_o |-> vector_addr_o == 13'h0004;
  endproperty
  a_vaddr: assert property (p_vaddr) else $error("wrong vector address");
  property p_global_off;
    vector_load_o |=> !irq_request_o;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request kept after entry");
  property p_pc;
    vector_load_o |-> stack_data_o == $past(return_pc_i);
  endproperty
  a_pc: assert property (p_pc) else $error("pushed address wrong");
  property p_q1;
    vector_load_o |-> $past(q1_i);
  endproperty
  a_q1: assert property (p_q1) else $error("vector not on a Q1 boundary");
  property p_pulse;
    vector_load_o |=> !vector_load_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("vector load too long");
  property p_wake;
    wake_o |-> $past(core_sleep_i);
  endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_rdata;
    !$past(reg_re_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its slot");
  // Main scenarios reached.
  c_vec: cover property (vector_load_o);
  c_wake: cover property (wake_o);
  c_read: cover property (reg_rdata_o != 8'h00);
endmodule // mic_ic_props

bind mic_interrupt_controller mic_ic_props #(.PC_WIDTH(PC_WIDTH)) u_props (
  .clock_i(clock_i), .srst_i(srst_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .q1_i(q1_i), .core_sleep_i(core_sleep_i), .return_pc_i(return_pc_i),
  .irq_request_o(irq_request_o), .wake_o(wake_o), .vector_load_o(vector_load_o),
  .vector_addr_o(vector_addr_o), .stack_push_o(stack_push_o), .stack_data_o(stack_data_o)
);
`default_nettype wire

// *** tb/mic_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Core sequencer: makes Q1 strobes and the return step of service code.
module mic_core_model (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ret_cmd_i,
  output logic q1_o,
  output logic return_from_service_o
);
  logic [1:0] phase_r;
  logic ret_pend_r;
  // A return waits for the next Q1 so it lands on an instruction boundary.
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      phase_r <= 2'd0;
      ret_pend_r <= 1'b0;
      q1_o <= 1'b0;
      return_from_service_o <= 1'b0;
    end
    else
    begin
      phase_r <= phase_r + 2'd1;
      q1_o <= (phase_r == 2'd3);
      return_from_service_o <= ret_pend_r && (phase_r == 2'd3);
      ret_pend_r <= (ret_pend_r && phase_r != 2'd3) || ret_cmd_i;
    end
  end
endmodule // mic_core_model
`default_nettype wire

// *** tb/test_mic_interrupt_controller.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_mic_interrupt_controller;
  logic clock_i = 0, srst_i = 1, we = 0, re = 0, sleep = 0, ret_cmd = 0, pread = 0, re_seen = 0;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [5:0] pins = 0, pval;
  logic [4:0] ev = 0;
  logic [12:0] rpc = 0, vaddr, sdata;
  logic q1, rfs, irq, wake, vload, spush;
  logic [31:0] rnd;
  logic [7:0] expq[$];
  logic [55:0] ra = 56'h40_9691_818c_0c0b, rv = 56'h00_00ff_ff00_0000;
  integer bad_count = 0, n_compared = 0, seed = 32'h24e2_02da, i, j;

  always #5 clock_i = ~clock_i;

  mic_interrupt_controller dut (.clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .q1_i(q1), .core_sleep_i(sleep),
    .return_from_service_i(rfs), .return_pc_i(rpc), .port_read_i(pread), .irq_request_o(irq), .wake_o(wake),
    .vector_load_o(vload), .vector_addr_o(vaddr), .stack_push_o(spush), .stack_data_o(sdata),
    .port_a_value_o(pval), .port_a_pins_i(pins), .timer_zero_ovf_i(ev[0]), .timer1_rollover_i(ev[1]),
    .comparator_change_i(ev[2]), .conv_done_i(ev[3]), .eeprom_done_i(ev[4]));
  mic_core_model core (.clock_i(clock_i), .srst_i(srst_i), .ret_cmd_i(ret_cmd), .q1_o(q1),
    .return_from_service_o(rfs));

  task conclude;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task check(input logic [12:0] seen, input logic [12:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Bus cycles leave one idle cycle so a strobe is never reassigned in one step.
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clock_i);
      we <= 1'b0;
      @(posedge clock_i);
    end
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    begin
      expq.push_back(e);
      addr <= a;
      re <= 1'b1;
      @(posedge clock_i);
      re <= 1'b0;
      @(posedge clock_i);
    end
  endtask

  task pin(input logic [5:0] v, input logic [5:0] e);
    begin
      pins <= v;
      repeat (8) @(negedge clock_i);
      check(pval, e);
      @(posedge clock_i);
    end
  endtask

  task wait_vec(input logic [12:0] pc);
    begin
      for (i = 0; i < 200 && vload !== 1'b1; i = i + 1)
        @(negedge clock_i);
      check(vload, 1'b1);
      check(sdata, pc);
      check(vaddr, 13'h0004);
      if (i == 200)
        conclude;
      @(posedge clock_i);
    end
  endtask

  // Read data stand in the cycle after the strobe; compare against the oldest note.
  always @(posedge clock_i)
    re_seen <= re;
  always @(negedge clock_i)
    if (re_seen && expq.size() > 0)
      check(rdata, expq.pop_front());

  initial
  begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    for (j = 0; j < 7; j = j + 1)
      rd(ra[8*j +: 8], rv[8*j +: 8]);
    $display("Test reset done");
    for (j = 0; j < 5; j = j + 1)
    begin
      ev <= 5'h01 << j;
      @(posedge clock_i);
      ev <= 5'h00;
      @(posedge clock_i);
    end
    rd(8'h0b, 8'h04);
    rd(8'h0c, 8'hc9);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h00);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'hc9);
    $display("Test flags done");
    wr(8'h8c, 8'h08);
    wr(8'h0b, 8'h40);
    sleep <= 1'b1;
    for (j = 0; j < 20 && wake !== 1'b1; j = j + 1)
      @(negedge clock_i);
    check(wake, 1'b1);
    check(irq, 1'b0);
    if (j == 20)
      conclude;
    @(posedge clock_i);
    sleep <= 1'b0;
    wr(8'h8c, 8'h00);
    wr(8'h0c, 8'h00);
    $display("Test wake done");
    rnd = $random(seed);
    rpc <= rnd[12:0];
    wr(8'h0b, 8'ha4);
    wait_vec(rnd[12:0]);
    rd(8'h0b, 8'h24);
    rnd = $random(seed);
    rpc <= rnd[12:0];
    ret_cmd <= 1'b1;
    @(posedge clock_i);
    ret_cmd <= 1'b0;
    wait_vec(rnd[12:0]);
    wr(8'h0b, 8'h00);
    $display("Test vector done");
    pin(6'h04, 6'h00);
    pin(6'h00, 6'h00);
    rd(8'h0b, 8'h00);
    wr(8'h91, 8'h00);
    pin(6'h04, 6'h04);
    rd(8'h0b, 8'h02);
    wr(8'h81, 8'hbf);
    wr(8'h0b, 8'h00);
    pin(6'h00, 6'h00);
    rd(8'h0b, 8'h02);
    wr(8'h0b, 8'h00);
    pin(6'h04, 6'h04);
    rd(8'h0b, 8'h00);
    $display("Test pin done");
    wr(8'h96, 8'h01);
    pin(6'h05, 6'h05);
    rd(8'h0b, 8'h01);
    pread <= 1'b1;
    @(posedge clock_i);
    pread <= 1'b0;
    wr(8'h0b, 8'h00);
    rd(8'h0b, 8'h00);
    $display("Test change done");
    conclude;
  end
endmodule // test_mic_interrupt_controller
`default_nettype wire
